/* shared/rsf_defs.vh */
// constants for the reset cause and enable register block
`ifndef RSF_DEFS_VH
`define RSF_DEFS_VH
`define RSF_ADDR        8'hef
`define RSF_BIT_USB     7
`define RSF_BIT_FLASH   6
`define RSF_BIT_CMP     5
`define RSF_BIT_SOFT    4
`define RSF_BIT_WDOG    3
`define RSF_BIT_CLKLOSS 2
`define RSF_BIT_POR     1
`define RSF_BIT_PIN     0
`define RSF_WDOG_DIV    12
`define RSF_RST_HOLD    4
`endif

/* hw/rsf_sync.v */
// two flip-flop synchroniser for a vector of pin inputs
`timescale 1ns/10ps
`default_nettype none
module rsf_sync #(
    parameter W = 1
) (
    // clock and reset
    input  wire         clock,
    input  wire         rst,
    // data
    input  wire [W-1:0] din,
    output reg  [W-1:0] dout
);
    reg [W-1:0] meta_r;

    // first stage feeds second stage only
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            meta_r <= {W{1'b0}};
            dout   <= {W{1'b0}};
        end else begin
            meta_r <= din;
            dout   <= meta_r;
        end
    end
endmodule // rsf_sync
`default_nettype wire

/* hw/rsf_top.v */
// reset cause capture, reset source enables and system reset request
`timescale 1ns/10ps
`default_nettype none
`include "rsf_defs.vh"
module rsf_top #(
    parameter HOLD = `RSF_RST_HOLD
) (
    // clock and reset (rst = power-on / supply monitor reset)
    input  wire       clock,
    input  wire       rst,
    // special-function register port
    input  wire [7:0] sfr_addr,
    input  wire [7:0] sfr_wdata,
    input  wire       sfr_wr,
    input  wire       sfr_rd,
    output reg  [7:0] sfr_rdata,
    // asynchronous reset sources
    input  wire       ext_pin_n,
    input  wire       usb_bus_reset,
    input  wire       vbus_level,
    input  wire       cmp0_out,
    input  wire       clock_loss_detector,
    input  wire       supply_low,
    // synchronous reset sources
    input  wire       wdog_overflow,
    input  wire       flash_fault,
    // enable the supply monitor separately kept elsewhere
    // system outputs
    output reg        sys_reset,
    output reg        clock_loss_en,
    output reg        supply_reset_en,
    output reg        wdog_enable,
    output reg        wdog_tick
);
    // ==========================================================
    // synchronised pins
    // ==========================================================
    wire [5:0] s;
    rsf_sync #(.W(6)) u_sync (
        .clock (clock),
        .rst   (rst),
        .din   ({~ext_pin_n, usb_bus_reset, vbus_level, ~cmp0_out,
                 clock_loss_detector, supply_low}),
        .dout  (s)
    );
    wire pin_s  = s[5];
    wire usb_s  = s[4];
    wire vbus_s = s[3];
    wire cmpl_s = s[2];
    wire mcd_s  = s[1];
    wire sup_s  = s[0];

    // ==========================================================
    // state and constants
    // ==========================================================
    // reset sequencer states
    localparam ST_IDLE = 1'b0;   // sources watched, writes taken
    localparam ST_HOLD = 1'b1;   // internal reset being stretched

    // last count of the watchdog clock divider
    localparam integer DIV_LAST = `RSF_WDOG_DIV - 1;

    reg       state_r;
    reg       vbus_d_r;
    reg       usb_en_r;
    reg       cmp_en_r;
    reg [7:0] flags_r;
    reg [7:0] cause_r;
    reg [3:0] hold_r;
    reg [3:0] div_r;

    // ==========================================================
    // helper functions
    // ==========================================================
    // register decode, shared by the read and write paths
    function addr_match;
        input [7:0] addr;
        begin
            addr_match = (addr == `RSF_ADDR);
        end
    endfunction

    // divider end of count, shared by wrap and tick
    function div_wrap;
        input [3:0] cnt;
        begin
            div_wrap = (cnt == DIV_LAST[3:0]);
        end
    endfunction

    // ==========================================================
    // register hits
    // ==========================================================
    // reset in progress, writes are refused meanwhile
    wire busy = (state_r == ST_HOLD);

    // register reached whatever page is selected
    wire wr_hit = sfr_wr && addr_match(sfr_addr);
    wire rd_hit = sfr_rd && addr_match(sfr_addr);

    // ==========================================================
    // cause detection
    // ==========================================================
    // detect causes in priority order, one cause per reset
    reg [7:0] cause_nxt;
    always @* begin
        cause_nxt = 8'h00;
        if (sup_s && supply_reset_en)
            cause_nxt[`RSF_BIT_POR] = 1'b1;
        else if (pin_s)
            cause_nxt[`RSF_BIT_PIN] = 1'b1;
        else if (mcd_s && clock_loss_en)
            cause_nxt[`RSF_BIT_CLKLOSS] = 1'b1;
        else if (usb_en_r && (usb_s || (vbus_s != vbus_d_r)))
            cause_nxt[`RSF_BIT_USB] = 1'b1;
        else if (cmpl_s && cmp_en_r)
            cause_nxt[`RSF_BIT_CMP] = 1'b1;
        else if (flash_fault)
            cause_nxt[`RSF_BIT_FLASH] = 1'b1;
        else if (wdog_overflow)
            cause_nxt[`RSF_BIT_WDOG] = 1'b1;
        else if (wr_hit && sfr_wdata[`RSF_BIT_SOFT])
            cause_nxt[`RSF_BIT_SOFT] = 1'b1;
    end

    // ==========================================================
    // reset sequencer
    // ==========================================================
    // write taken only when idle and no cause is pending
    wire take_wr   = !busy && (cause_nxt == 8'h00) && wr_hit;
    // last cycle of an internal reset
    wire hold_done = busy && (hold_r == 4'h0);

    // previous bus-supply level, any change is an edge
    always @(posedge clock or posedge rst) begin
        if (rst)
            vbus_d_r <= 1'b0;
        else
            vbus_d_r <= vbus_s;
    end

    // cause capture and reset pulse
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            state_r   <= ST_IDLE;
            flags_r   <= 8'h02;
            cause_r   <= 8'h00;
            hold_r    <= 4'h0;
            sys_reset <= 1'b0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (cause_nxt != 8'h00) begin
                        state_r   <= ST_HOLD;
                        sys_reset <= 1'b1;
                        hold_r    <= HOLD[3:0];
                        cause_r   <= cause_nxt;
                    end
                end
                ST_HOLD: begin
                    if (hold_r == 4'h0) begin
                        state_r   <= ST_IDLE;
                        sys_reset <= 1'b0;
                        flags_r   <= cause_r;
                    end else begin
                        hold_r <= hold_r - 4'h1;
                    end
                end
                default: begin
                    state_r   <= ST_IDLE;
                    sys_reset <= 1'b0;
                end
            endcase
        end
    end

    // ==========================================================
    // reset source enables
    // ==========================================================
    // enables cleared by every internal reset except supply
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            usb_en_r        <= 1'b0;
            cmp_en_r        <= 1'b0;
            clock_loss_en   <= 1'b0;
            supply_reset_en <= 1'b1;
        end else if (hold_done) begin
            // a reset from any source drops the optional enables
            usb_en_r      <= 1'b0;
            cmp_en_r      <= 1'b0;
            clock_loss_en <= 1'b0;
        end else if (take_wr) begin
            usb_en_r        <= sfr_wdata[`RSF_BIT_USB];
            cmp_en_r        <= sfr_wdata[`RSF_BIT_CMP];
            clock_loss_en   <= sfr_wdata[`RSF_BIT_CLKLOSS];
            supply_reset_en <= sfr_wdata[`RSF_BIT_POR];
        end
    end

    // ==========================================================
    // read data
    // ==========================================================
    // read data shows cause flags, not enables
    always @(posedge clock or posedge rst) begin
        if (rst)
            sfr_rdata <= 8'h00;
        else if (rd_hit)
            sfr_rdata <= flags_r;
        else
            sfr_rdata <= 8'h00;
    end

    // ==========================================================
    // watchdog clocking
    // ==========================================================
    // watchdog enabled after every reset, tick at clock over twelve
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            div_r       <= 4'h0;
            wdog_enable <= 1'b1;
            wdog_tick   <= 1'b0;
        end else begin
            if (busy)
                wdog_enable <= 1'b1;
            if (busy || div_wrap(div_r))
                div_r <= 4'h0;
            else
                div_r <= div_r + 4'h1;
            wdog_tick <= !busy && div_wrap(div_r);
        end
    end
endmodule // rsf_top
`default_nettype wire

/* verif/rsf_properties.sv */
// assertions on the reset cause register block ports
`timescale 1ns/10ps
`default_nettype none
module rsf_properties (
    // clock, reset, register port
    input wire logic       clock,
    input wire logic       rst,
    input wire logic       sfr_wr,
    input wire logic       sfr_rd,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    // sources and outputs
    input wire logic       ext_pin_n,
    input wire logic       wdog_overflow,
    input wire logic       sys_reset,
    input wire logic       clock_loss_en,
    input wire logic       supply_reset_en,
    input wire logic       wdog_enable,
    input wire logic       wdog_tick
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // ==========================================
    // register writes, unmapped reads and reset pulse
    sequence s_wr;
        sfr_wr && sfr_addr == 8'hef && !sys_reset;
    endsequence
    property p_soft; s_wr ##0 sfr_wdata[4] |=> sys_reset; endproperty
    a_soft: assert property (p_soft) else $error("no soft reset");
    property p_hold; $rose(sys_reset) |-> sys_reset[*5] ##1 !sys_reset;
    endproperty
    a_hold: assert property (p_hold) else $error("bad reset len");
    property p_clk;
        s_wr ##0 !sfr_wdata[4] |=> clock_loss_en == $past(sfr_wdata[2]);
    endproperty
    a_clk: assert property (p_clk) else $error("clock loss en");
    property p_sup;
        s_wr ##0 !sfr_wdata[4] |=> supply_reset_en == $past(sfr_wdata[1]);
    endproperty
    a_sup: assert property (p_sup) else $error("supply en");
    property p_map; sfr_rd && sfr_addr != 8'hef |=> sfr_rdata == 8'h00;
    endproperty
    a_map: assert property (p_map) else $error("unmapped read");
    // ==========================================
    // watchdog clocking and reset sources
    property p_tick;
        disable iff (rst || sys_reset)
        wdog_tick |=> !wdog_tick[*8] ##1 !wdog_tick[*3] ##1 wdog_tick;
    endproperty
    a_tick: assert property (p_tick) else $error("tick period");
    property p_wden; wdog_enable; endproperty
    a_wden: assert property (p_wden) else $error("wdog off");
    property p_pin;
        $fell(ext_pin_n) ##1 !ext_pin_n[*2] |-> ##[1:3] sys_reset;
    endproperty
    a_pin: assert property (p_pin) else $error("no pin reset");
    property p_wdog; wdog_overflow && !sys_reset |-> ##[1:3] sys_reset;
    endproperty
    a_wdog: assert property (p_wdog) else $error("no wdog reset");
endmodule // rsf_properties
bind rsf_top rsf_properties u_props (.clock, .rst, .sfr_wr, .sfr_rd,
    .sfr_addr, .sfr_wdata, .sfr_rdata, .ext_pin_n, .wdog_overflow,
    .sys_reset, .clock_loss_en, .supply_reset_en, .wdog_enable, .wdog_tick);
`default_nettype wire

/* verif/rsf_top_test.sv */
// self-checking bench for the reset cause register block
`timescale 1ns/10ps
`default_nettype none
module rsf_top_test;
    logic        clock = 1'h0, rst = 1'h1, sfr_wr = 1'h0, sfr_rd = 1'h0;
    logic        vbus_level = 1'h0, sys_reset, clock_loss_en;
    logic        supply_reset_en, wdog_enable, wdog_tick;
    logic [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
    logic [7:0]  src = 8'h00, e, wd;
    logic [15:0] seed = 16'h4005;
    int          errors = 0, n_tests = 0;
    // device under test, sources other than vbus_level taken from one vector
    rsf_top #(.HOLD(4)) dut (.clock, .rst, .sfr_addr, .sfr_wdata, .sfr_wr,
        .sfr_rd, .sfr_rdata, .ext_pin_n(~src[0]), .usb_bus_reset(src[7]),
        .vbus_level, .cmp0_out(~src[5]), .clock_loss_detector(src[2]),
        .supply_low(src[1]), .wdog_overflow(src[3]), .flash_fault(src[6]),
        .sys_reset, .clock_loss_en, .supply_reset_en, .wdog_enable,
        .wdog_tick);
    always #10 clock = ~clock;
    // expected flag of each case, 8 is a bus-supply edge
    function automatic logic [7:0] flag_of(int i);
        return i == 8 ? 8'h80 : 8'h01 << i;
    endfunction
    function automatic logic [7:0] rnd();
        seed ^= seed << 7;
        seed ^= seed >> 9;
        seed ^= seed << 8;
        return seed[7:0];
    endfunction
    task automatic chk(string nm, logic [7:0] x, logic [7:0] g);
        n_tests++;
        if (g !== x) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, x, g);
        end
    endtask
    // one register cycle, read data looked at one edge later
    task automatic acc(logic w, logic [7:0] a, logic [7:0] d);
        @(negedge clock);
        {sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = {w, !w, a, d};
        @(negedge clock);
        {sfr_wr, sfr_rd} = 2'h0;
    endtask
    task automatic wait_rst(logic v);
        for (int k = 0; k < 20 && sys_reset !== v; k++) @(negedge clock);
        chk("sys_reset", {7'h00, v}, {7'h00, sys_reset});
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #100000;
        errors++;
        close_out();
    end
    initial begin
        repeat (12) @(negedge clock);
        rst = 1'h0;
        acc(1'h0, 8'hef, 8'h00);
        chk("flags", 8'h02, sfr_rdata);
        repeat (4) begin
            acc(1'h0, 8'hef ^ (rnd() | 8'h01), 8'h00);
            chk("unmapped", 8'h00, sfr_rdata);
        end
        $display("test power-on done");
        for (int i = 0; i < 9; i++) begin
            e = flag_of(i);
            wd = (i inside {0, 3, 6} ? 8'h00 : e) | (rnd() & 8'h49);
            acc(1'h1, 8'hef, wd);
            if (i == 8) vbus_level = !vbus_level;
            else if (i != 4) src = e;
            @(negedge clock);
            src = src & 8'hb7;
            wait_rst(1'h1);
            src = 8'h00;
            wait_rst(1'h0);
            acc(1'h0, 8'hef, 8'h00);
            chk("flags", e, sfr_rdata);
            chk("clock_loss_en", 8'h00, {7'h00, clock_loss_en});
            chk("supply_en", {7'h00, i == 1}, {7'h00, supply_reset_en});
            chk("wdog_enable", 8'h01, {7'h00, wdog_enable});
            $display("test %0d done", i);
        end
        // enable clock loss only, then a power-on reset in mid-run
        acc(1'h1, 8'hef, 8'h04);
        chk("clock_loss_en", 8'h01, {7'h00, clock_loss_en});
        chk("supply_en", 8'h00, {7'h00, supply_reset_en});
        @(negedge clock);
        rst = 1'h1;
        repeat (2) @(negedge clock);
        rst = 1'h0;
        chk("clock_loss_en", 8'h00, {7'h00, clock_loss_en});
        chk("supply_en", 8'h01, {7'h00, supply_reset_en});
        chk("wdog_enable", 8'h01, {7'h00, wdog_enable});
        acc(1'h0, 8'hef, 8'h00);
        chk("flags", 8'h02, sfr_rdata);
        // watchdog tick comes once every twelve clocks
        for (int k = 0; k < 20 && wdog_tick !== 1'h1; k++)
            @(negedge clock);
        repeat (11) begin
            @(negedge clock);
            chk("wdog_tick", 8'h00, {7'h00, wdog_tick});
        end
        @(negedge clock);
        chk("wdog_tick", 8'h01, {7'h00, wdog_tick});
        $display("test reset done");
        close_out();
    end
endmodule // rsf_top_test
`default_nettype wire
